// ===== core/eps_serial_port.v
`timescale 1ns/1ps
`include "eps_serial_map.vh"

module eps_serial_port (
  input  wire       ref_clk_in,
  input  wire       rst_n_in,
  input  wire       bus_select_strap_in,
  input  wire       serial_clk_in,
  input  wire       serial_in,
  input  wire       chip_select_n_in,
  input  wire       data_cmd_in,
  input  wire       core_busy_in,
  output reg        serial_data_out,
  output reg        serial_data_oe_out,
  output reg  [7:0] ram_data_out,
  output reg        ram_write_out,
  output reg  [7:0] cmd_data_out,
  output reg        cmd_write_out,
  output reg        busy_out_n,
  output reg        three_wire_mode_out
);

  // ************************************************
  // internal state
  // ************************************************
  reg  [1:0] sync_clk;
  reg  [1:0] sync_din;
  reg  [1:0] sync_cs;
  reg  [1:0] sync_dc;
  reg  [1:0] sync_bs;
  reg        clk_prev;
  reg  [7:0] shift;
  reg        sel_bit;
  reg  [3:0] bit_cnt;
  reg        mode;
  reg        strap_taken;
  reg  [3:0] next_bit_cnt;
  wire       clk_rise;
  wire       cs_active;
  wire       bit_take;
  wire       sel_slot;
  wire       frame_end;
  wire       to_ram;
  wire [3:0] frame_len;
  wire [7:0] byte_done;

  // ************************************************
  // shared decoding
  // ************************************************
  // frame length in serial clocks for the captured mode
  function [3:0] frame_bits;
    input m;
    frame_bits = (m == `EPS_MODE_THREE_WIRE) ? `EPS_BITS_THREE_WIRE : `EPS_BITS_FOUR_WIRE;
  endfunction

  // shifter contents with the arriving bit put in at the lsb
  function [7:0] join_bit;
    input [7:0] sh;
    input       b;
    join_bit = {sh[6:0], b};
  endfunction

  // 3-wire trusts only the frame's own selector; the dc pin is ignored
  function route_ram;
    input m;
    input sel;
    input dc;
    if (m == `EPS_MODE_THREE_WIRE)
      route_ram = (sel == `EPS_SEL_DATA);
    else
      route_ram = (dc == `EPS_SEL_DATA);
  endfunction

  // ************************************************
  // input synchronisers
  // ************************************************
  // two flops per pin; only the second stage feeds logic
  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      sync_clk <= `EPS_SYNC_LOW;
      clk_prev <= `EPS_BIT_LOW;
    end else begin
      sync_clk <= {sync_clk[0], serial_clk_in};
      clk_prev <= sync_clk[1];
    end
  end

  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      sync_din <= `EPS_SYNC_LOW;
    end else begin
      sync_din <= {sync_din[0], serial_in};
    end
  end

  // deselected level in reset so no frame can start during it
  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      sync_cs <= `EPS_SYNC_HIGH;
    end else begin
      sync_cs <= {sync_cs[0], chip_select_n_in};
    end
  end

  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      sync_dc <= `EPS_SYNC_LOW;
    end else begin
      sync_dc <= {sync_dc[0], data_cmd_in};
    end
  end

  // strap sync runs through reset so its level is settled at release
  always @(posedge ref_clk_in) begin
    sync_bs <= {sync_bs[0], bus_select_strap_in};
  end

  // ************************************************
  // edge detect and frame position
  // ************************************************
  assign clk_rise  = sync_clk[1] & ~clk_prev;
  assign cs_active = ~sync_cs[1];
  assign bit_take  = cs_active & clk_rise;
  assign frame_len = frame_bits(mode);
  assign sel_slot  = (mode == `EPS_MODE_THREE_WIRE) && (bit_cnt == `EPS_CNT_RESET);
  assign byte_done = join_bit(shift, sync_din[1]);
  assign to_ram    = route_ram(mode, sel_bit, sync_dc[1]);
  assign frame_end = bit_take && (next_bit_cnt == `EPS_CNT_RESET);

  always @* begin
    next_bit_cnt = bit_cnt + `EPS_CNT_STEP;
    if (next_bit_cnt == frame_len) begin
      next_bit_cnt = `EPS_CNT_RESET;
    end
  end

  // ************************************************
  // mode strap, caught once after reset release
  // ************************************************
  // strap is a board level; re-reading it mid-session would corrupt framing
  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      mode        <= `EPS_MODE_FOUR_WIRE;
      strap_taken <= `EPS_BIT_LOW;
    end else if (!strap_taken) begin
      mode        <= sync_bs[1];
      strap_taken <= `EPS_BIT_HIGH;
    end
  end

  // ************************************************
  // bit counter, shifter and selector
  // ************************************************
  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      bit_cnt <= `EPS_CNT_RESET;
    end else if (!cs_active) begin
      bit_cnt <= `EPS_CNT_RESET;
    end else if (clk_rise) begin
      bit_cnt <= next_bit_cnt;
    end
  end

  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      shift <= `EPS_BYTE_RESET;
    end else if (!cs_active) begin
      shift <= `EPS_BYTE_RESET;
    end else if (clk_rise && !sel_slot) begin
      shift <= join_bit(shift, sync_din[1]);
    end
  end

  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      sel_bit <= `EPS_SEL_CMD;
    end else if (bit_take && sel_slot) begin
      sel_bit <= sync_din[1];
    end
  end

  // ************************************************
  // byte routing
  // ************************************************
  // strobes last one cycle; the byte holds until the next write of its kind
  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      ram_data_out  <= `EPS_BYTE_RESET;
      ram_write_out <= `EPS_BIT_LOW;
    end else begin
      ram_write_out <= `EPS_BIT_LOW;
      if (frame_end && to_ram) begin
        ram_data_out  <= byte_done;
        ram_write_out <= `EPS_BIT_HIGH;
      end
    end
  end

  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      cmd_data_out  <= `EPS_BYTE_RESET;
      cmd_write_out <= `EPS_BIT_LOW;
    end else begin
      cmd_write_out <= `EPS_BIT_LOW;
      if (frame_end && !to_ram) begin
        cmd_data_out  <= byte_done;
        cmd_write_out <= `EPS_BIT_HIGH;
      end
    end
  end

  // ************************************************
  // status outputs
  // ************************************************
  // write-only port: the data pin never leaves input mode
  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      serial_data_out    <= `EPS_BIT_LOW;
      serial_data_oe_out <= `EPS_BIT_LOW;
    end else begin
      serial_data_out    <= `EPS_BIT_LOW;
      serial_data_oe_out <= `EPS_BIT_LOW;
    end
  end

  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      busy_out_n <= `EPS_BUSY_IDLE_N;
    end else begin
      busy_out_n <= ~core_busy_in;
    end
  end

  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      three_wire_mode_out <= `EPS_MODE_FOUR_WIRE;
    end else begin
      three_wire_mode_out <= mode;
    end
  end

endmodule

// ===== core/eps_serial_map.vh
`ifndef EPS_SERIAL_MAP_VH
`define EPS_SERIAL_MAP_VH
// ************************************************
// mode strap levels
// ************************************************
`define EPS_MODE_FOUR_WIRE  1'h0
`define EPS_MODE_THREE_WIRE 1'h1
// ************************************************
// frame lengths in serial clocks
// ************************************************
`define EPS_BITS_FOUR_WIRE  4'h8
`define EPS_BITS_THREE_WIRE 4'h9
`define EPS_CNT_RESET       4'h0
`define EPS_CNT_STEP        4'h1
// ************************************************
// data/command selector levels
// ************************************************
`define EPS_SEL_DATA        1'h1
`define EPS_SEL_CMD         1'h0
// ************************************************
// reset values
// ************************************************
`define EPS_BYTE_RESET      8'h00
`define EPS_SYNC_LOW        2'h0
`define EPS_SYNC_HIGH       2'h3
`define EPS_BIT_LOW         1'h0
`define EPS_BIT_HIGH        1'h1
`define EPS_BUSY_IDLE_N     1'h1
`endif

// ===== test/eps_host_model.sv
`timescale 1ns/1ps
// ****
// host
// ****
module eps_host_model (
  output logic sclk_out = 0,
  output logic serial_in_out = 0,
  output logic csn_out = 1,
  output logic dc_out = 0
);
  task automatic xfer(input int n, input logic [8:0] w, input logic c, input logic d);
    csn_out = c;
    dc_out = d;
    #150;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in_out = w[i];
      #100 sclk_out = 1;
      #100 sclk_out = 0;
    end
    #100 csn_out = 1;
    serial_in_out = ~serial_in_out; // released line: no stale level
  endtask
endmodule

// ===== test/eps_serial_chk.sv
`timescale 1ns/1ps
// ****
// checks
// ****
module eps_serial_chk (
  input logic ref_clk_in,
  input logic rst_n_in,
  input logic chip_select_n_in,
  input logic core_busy_in,
  input logic serial_data_out,
  input logic serial_data_oe_out,
  input logic [7:0] ram_data_out,
  input logic [7:0] cmd_data_out,
  input logic ram_write_out,
  input logic cmd_write_out,
  input logic busy_out_n,
  input logic three_wire_mode_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_pin_released: assert property (!serial_data_oe_out && !serial_data_out) else $error("pin driven");
  a_ram_pulse: assert property (ram_write_out |=> !ram_write_out) else $error("ram pulse long");
  a_cmd_pulse: assert property (cmd_write_out |=> !cmd_write_out) else $error("cmd pulse long");
  a_one_target: assert property (!(ram_write_out && cmd_write_out)) else $error("two targets");
  a_ram_hold: assert property (!ram_write_out |-> $stable(ram_data_out)) else $error("ram byte moved");
  a_cmd_hold: assert property (!cmd_write_out |-> $stable(cmd_data_out)) else $error("cmd byte moved");
  a_busy_follow: assert property ($past(rst_n_in) |-> busy_out_n == !$past(core_busy_in)) else $error("busy");
  a_cs_ignore: assert property (chip_select_n_in[*8] |-> !ram_write_out && !cmd_write_out) else $error("cs");
  a_mode_fixed: assert property (rst_n_in[*4] |=> $stable(three_wire_mode_out)) else $error("mode moved");
endmodule
bind eps_serial_port eps_serial_chk u_chk (
  .ref_clk_in          (ref_clk_in),
  .rst_n_in            (rst_n_in),
  .chip_select_n_in    (chip_select_n_in),
  .core_busy_in        (core_busy_in),
  .serial_data_out     (serial_data_out),
  .serial_data_oe_out  (serial_data_oe_out),
  .ram_data_out        (ram_data_out),
  .cmd_data_out        (cmd_data_out),
  .ram_write_out       (ram_write_out),
  .cmd_write_out       (cmd_write_out),
  .busy_out_n          (busy_out_n),
  .three_wire_mode_out (three_wire_mode_out)
);

// ===== test/testbench.sv
`timescale 1ns/1ps
// ****
// bench
// ****
module testbench;
  logic ref_clk_in = 0, rst_n_in = 0, bus_select_strap_in = 0, core_busy_in = 0;
  wire serial_clk_in, serial_in, chip_select_n_in, data_cmd_in, serial_data_out, serial_data_oe_out;
  wire ram_write_out, cmd_write_out, busy_out_n, three_wire_mode_out;
  wire [7:0] ram_data_out, cmd_data_out;
  int err_count = 0, num_checks = 0, cyc = 0, nr = 0, nc = 0;
  always #12.5 ref_clk_in = ~ref_clk_in;
  eps_host_model host (.sclk_out(serial_clk_in), .serial_in_out(serial_in), .csn_out(chip_select_n_in), .dc_out(data_cmd_in));
  eps_serial_port DUT (
    .ref_clk_in          (ref_clk_in),
    .rst_n_in            (rst_n_in),
    .bus_select_strap_in (bus_select_strap_in),
    .serial_clk_in       (serial_clk_in),
    .serial_in           (serial_in),
    .chip_select_n_in    (chip_select_n_in),
    .data_cmd_in         (data_cmd_in),
    .core_busy_in        (core_busy_in),
    .serial_data_out     (serial_data_out),
    .serial_data_oe_out  (serial_data_oe_out),
    .ram_data_out        (ram_data_out),
    .ram_write_out       (ram_write_out),
    .cmd_data_out        (cmd_data_out),
    .cmd_write_out       (cmd_write_out),
    .busy_out_n          (busy_out_n),
    .three_wire_mode_out (three_wire_mode_out)
  );
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    nr <= nr + (ram_write_out === 1'h1);
    nc <= nc + (cmd_write_out === 1'h1);
    if (cyc == 6000) begin
      err_count++;
      complete_run;
    end
  end
  task chk(string s, logic [8:0] e, logic [8:0] v);
    num_checks++;
    if (v !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", s, e, v);
    end
  endtask
  task frame(int n, logic [8:0] w, logic c, logic d, int er, int ec);
    int r0, c0;
    r0 = nr;
    c0 = nc;
    @(posedge ref_clk_in);
    #1;
    host.xfer(n, w, c, d);
    repeat (4) @(posedge ref_clk_in);
    #1;
    chk("ram_writes", er, nr - r0);
    chk("cmd_writes", ec, nc - c0);
    if (er) chk("ram_byte", w[7:0], ram_data_out);
    if (ec) chk("cmd_byte", w[7:0], cmd_data_out);
  endtask
  task reset_to(logic m);
    rst_n_in = 0;
    bus_select_strap_in = m;
    repeat (6) @(posedge ref_clk_in);
    #1 rst_n_in = 1;
    repeat (6) @(posedge ref_clk_in);
    #1 chk("mode", m, three_wire_mode_out);
  endtask
  task t_four;
    frame(8, 9'h0A5, 0, 1, 1, 0);
    frame(8, 9'h03C, 0, 0, 0, 1);
    frame(8, 9'h0FF, 1, 1, 0, 0);
    frame(5, 9'h015, 0, 1, 0, 0);
    frame(8, 9'h081, 0, 1, 1, 0);
  endtask
  task t_three;
    frame(9, 9'h196, 0, 0, 1, 0);
    frame(9, 9'h04B, 0, 0, 0, 1);
  endtask
  task t_busy;
    @(posedge ref_clk_in) #1 core_busy_in = 1;
    repeat (2) @(posedge ref_clk_in);
    #1 chk("busy_n", 0, busy_out_n);
    core_busy_in = 0;
    repeat (2) @(posedge ref_clk_in);
    #1 chk("busy_n", 1, busy_out_n);
    chk("pin_oe", 0, serial_data_oe_out);
    chk("pin_data", 0, serial_data_out);
  endtask
  task complete_run;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    reset_to(0);
    t_four;
    t_busy;
    reset_to(1);
    t_three;
    complete_run;
  end
endmodule
